// ===== logic/stub_readout.sv
`timescale 1ns/100ps
`include "stub_readout_params.svh"

module seg_fifo #(
  parameter int WIDTH = 39,
  parameter int DEPTH = `FIFO_DEPTH,
  localparam int AW   = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  input  wire logic             out_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  output logic      [AW:0]      count
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign in_ready  = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_q];
  assign count     = count_q;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Behaviour
// - Correlation match bits are captured at each crossing period boundary.
// - Lower channel addresses win over higher ones when selecting segments.
// - Each segment is 8-bit address plus 4-bit slope, registered on the tick.
// - At most three segments per period, lowest addresses, slope ignored.
// - Overflow flag in the packet when more than three segments were found.
// - Fifteen writable registers map 5-bit slope codes to 4-bit codes.
// - Table entries reset to upper four code bits; code 10000 gives 1000.
// - Packet goes out on five lanes, MSB and sync bit first per frame.
// - Data for a period shows on the lanes five periods later, one frame.
// - Any-hit flag set when any of the 254 channels saw a hit.
// - Packet error flag is buffer-full OR delay-error; both kept readable.
// - Sync bit is sent in every packet outside the pause after soft reset, once per eight bit slots.
// - Triggered-data header slot marker lines up with the sync bit slot.
// - Soft reset drops queued data, pauses sync, sync returns before data.
// - Frame bits 4,3,2,1: soft reset, trigger, calibration, counter clear.
// - Pattern 110 on bits 7:5 with bit 0 set makes the period tick; tick halts without it.
// - Sync-lost and sync-status flags readable; soft reset clears sync-lost, not sync-status.
// - Only counter clear combines; other combinations flag error, no command.
// - Soft reset starts on the tick and lasts one and a half periods.
// - Decoded trigger is delivered in the period after its frame.
// - Frames arrive MSB first, one bit per clock cycle.
// - Every command but soft reset lasts exactly one period unless repeated.
module stub_readout
  import stub_readout_pkg::*;
#(
  parameter int CHANNELS = `CHANNELS,
  parameter int DEPTH    = `FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  // Serial fast command
  input  wire logic                       fcmd_bit,
  // Correlation results
  input  wire logic [CHANNELS-1:0]        match_bits,
  input  wire stub_readout_pkg::bend_t [CHANNELS-1:0] bend_codes,
  input  wire logic [CHANNELS-1:0]        hit_bits,
  input  wire logic                       buf_full_in,
  input  wire logic                       delay_err_in,
  // Slope table access
  input  wire logic                       tbl_wr_en,
  input  wire logic [3:0]                 tbl_idx,
  input  wire logic [7:0]                 tbl_wr_data,
  output logic      [7:0]                 tbl_rd_data,
  // Status and decoded commands
  output stub_readout_pkg::status_t       status,
  output stub_readout_pkg::fcmd_t         cmd,
  output logic                            tick40,
  // Serial packet lanes
  output logic      [`LANES-1:0]          lanes,
  output logic                            trig_hdr_slot
);
  import stub_readout_pkg::*;

  localparam int FW  = $bits(seg_pkt_t);
  localparam int CW  = $clog2(DEPTH) + 1;
  localparam int BPP = `BITS_PER_PERIOD;

  // Command decoder state
  lock_state_t    state_q;
  logic [7:0]     shreg_q;
  logic [2:0]     bitcnt_q;
  logic           frame_hit;
  logic           frame_ok;
  logic           forbidden;
  logic           srst_start;
  logic           tick_q;
  fcmd_t          cmd_q;
  logic [3:0]     hold_q;
  logic [3:0]     srst_cnt_q;
  status_t        status_q;

  // Readout path state
  logic [CHANNELS-1:0] match_q;
  bend_t [CHANNELS-1:0] bend_q;
  logic           any_hit_q;
  logic           err_cap_q;
  logic [7:0]     tbl_q [`TBL_REGS];
  seg_pkt_t       gath;
  logic [1:0]     skip_q;
  logic [1:0]     gap_q;
  logic           sync_en_q;
  logic           push;
  logic           pop;
  logic           fifo_ready;
  logic           fifo_valid;
  logic [FW-1:0]  fifo_out;
  logic [CW-1:0]  fifo_count;
  seg_pkt_t       pkt;
  logic [7:0]     lane_sh_q [`LANES];
  logic           hdr_q;

  // Frame MSB arrives first; one bit per clock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shreg_q <= '0;
    end else begin
      shreg_q <= {shreg_q[6:0], fcmd_bit};
    end
  end

  // Bit 0 guard keeps trigger plus calibration and soft reset plus trigger codes from faking the pattern
  assign frame_hit = (shreg_q[`SYNC_MSB:`SYNC_LSB] == `SYNC_PATTERN)
                     && shreg_q[`CMD_MARK];
  assign frame_ok  = frame_hit
                     && ((state_q == HUNT) || (bitcnt_q == 3'h7));
  assign forbidden = ($countones(shreg_q[`CMD_SOFT_RST:`CMD_CAL]) > 1);
  assign srst_start = frame_ok && !forbidden
                      && shreg_q[`CMD_SOFT_RST];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q  <= HUNT;
      bitcnt_q <= '0;
    end else begin
      bitcnt_q <= bitcnt_q + 3'h1;
      unique case (state_q)
        HUNT: begin
          if (frame_ok) begin
            state_q  <= LOCKED;
            bitcnt_q <= '0;
          end
        end
        LOCKED: begin
          if (bitcnt_q == 3'h7) begin
            bitcnt_q <= '0;
            if (!frame_hit) begin
              state_q <= HUNT;
            end
          end
        end
      endcase
    end
  end

  // The period tick stands still while the pattern is missing
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= frame_ok;
    end
  end

  // Decoded commands appear in the period after their frame
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd_q.trig <= 1'b0;
      cmd_q.cal  <= 1'b0;
      cmd_q.clr  <= 1'b0;
      hold_q     <= '0;
    end else if (frame_ok) begin
      cmd_q.trig <= !forbidden && shreg_q[`CMD_TRIG];
      cmd_q.cal  <= !forbidden && shreg_q[`CMD_CAL];
      cmd_q.clr  <= !forbidden && shreg_q[`CMD_CLR];
      hold_q     <= 4'(BPP);
    end else if (hold_q != '0) begin
      hold_q <= hold_q - 4'h1;
      if (hold_q == 4'h1) begin
        cmd_q.trig <= 1'b0;
        cmd_q.cal  <= 1'b0;
        cmd_q.clr  <= 1'b0;
      end
    end
  end

  // Soft reset is one and a half periods wide for clocked-reset users
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd_q.soft_rst <= 1'b0;
      srst_cnt_q     <= '0;
    end else if (srst_start) begin
      cmd_q.soft_rst <= 1'b1;
      srst_cnt_q     <= 4'(`SOFT_RST_BITS);
    end else if (srst_cnt_q != '0) begin
      srst_cnt_q <= srst_cnt_q - 4'h1;
      if (srst_cnt_q == 4'h1) begin
        cmd_q.soft_rst <= 1'b0;
      end
    end
  end

  // Status flags: an event in the clearing cycle still sets its flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      status_q.sync_ok <= (state_q == LOCKED) && !((bitcnt_q == 3'h7)
                          && !frame_hit);
      if ((state_q == LOCKED) && (bitcnt_q == 3'h7) && !frame_hit) begin
        status_q.sync_lost <= 1'b1;
      end else if (srst_start) begin
        status_q.sync_lost <= 1'b0;
      end
      if (frame_ok && forbidden) begin
        status_q.cmd_err <= 1'b1;
      end else if (srst_start) begin
        status_q.cmd_err <= 1'b0;
      end
      if (buf_full_in) begin
        status_q.buf_full <= 1'b1;
      end else if (srst_start) begin
        status_q.buf_full <= 1'b0;
      end
      if (delay_err_in) begin
        status_q.delay_err <= 1'b1;
      end else if (srst_start) begin
        status_q.delay_err <= 1'b0;
      end
    end
  end

  // Capture at the boundary so the gathering logic has a whole period
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      match_q   <= '0;
      bend_q    <= '0;
      any_hit_q <= 1'b0;
      err_cap_q <= 1'b0;
    end else if (tick_q) begin
      match_q   <= match_bits;
      bend_q    <= bend_codes;
      any_hit_q <= |hit_bits;
      err_cap_q <= buf_full_in || delay_err_in;
    end
  end

  // Slope table; codes 30 and 31 have no register and keep the default
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int r = 0; r < `TBL_REGS; r++) begin
        tbl_q[r] <= {4'(r), 4'(r)};
      end
    end else if (tbl_wr_en && (tbl_idx < 4'(`TBL_REGS))) begin
      tbl_q[tbl_idx] <= tbl_wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tbl_rd_data <= '0;
    end else if (tbl_idx < 4'(`TBL_REGS)) begin
      tbl_rd_data <= tbl_q[tbl_idx];
    end else begin
      tbl_rd_data <= '0;
    end
  end

  function automatic slope_t slope_map(input bend_t code);
    logic [7:0] entry;
    entry = '0;
    if (code < `TBL_PROG_CODES) begin
      entry = tbl_q[code[4:1]];
      slope_map = code[0] ? entry[7:4] : entry[3:0];
    end else begin
      slope_map = code[4:1];
    end
  endfunction

  // Ripple priority: scanning from channel 0 gives lower addresses first
  always_comb begin
    logic [2:0] n;
    n    = '0;
    gath = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      if (match_q[i]) begin
        if (n < 3'(`MAX_SEG)) begin
          gath.addr[n[1:0]]  = 8'(i);
          gath.slope[n[1:0]] = slope_map(bend_q[i]);
          n = n + 3'h1;
        end else begin
          n = 3'h4;
        end
      end
    end
    gath.overflow     = (n > 3'(`MAX_SEG));
    gath.any_hit_flag = any_hit_q;
    gath.err_flag     = err_cap_q;
  end

  // Discard after soft reset and pause of the sync bit
  // Three skipped pushes drop the reset period, the one before it and the next one, and
  // leave the sync bit back for three periods before the first data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      skip_q    <= '0;
      gap_q     <= '0;
      sync_en_q <= 1'b1;
    end else if (srst_start) begin
      skip_q    <= 2'h3;
      gap_q     <= 2'(`SYNC_GAP);
      sync_en_q <= 1'b0;
    end else if (tick_q) begin
      if (skip_q != '0) begin
        skip_q <= skip_q - 2'h1;
      end
      if (gap_q != '0) begin
        gap_q <= gap_q - 2'h1;
      end else begin
        sync_en_q <= 1'b1;
      end
    end
  end

  // A full queue drops the period's packet rather than stalling the tick
  assign push = tick_q && (skip_q == '0) && !cmd_q.soft_rst;
  assign pop  = tick_q && !cmd_q.soft_rst
                && (fifo_count >= CW'(`LAT_FILL));

  seg_fifo #(
    .WIDTH (FW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .flush     (cmd_q.soft_rst),
    .in_valid  (push),
    .in_data   (gath),
    .in_ready  (fifo_ready),
    .out_ready (pop),
    .out_valid (fifo_valid),
    .out_data  (fifo_out),
    .count     (fifo_count)
  );

  assign pkt = (pop && fifo_valid) ? seg_pkt_t'(fifo_out) : '0;

  // Frame load on the tick, then shift out MSB first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int l = 0; l < `LANES; l++) begin
        lane_sh_q[l] <= '0;
      end
    end else if (tick_q) begin
      lane_sh_q[0] <= pkt.addr[0];
      lane_sh_q[1] <= pkt.addr[1];
      lane_sh_q[2] <= pkt.addr[2];
      lane_sh_q[3] <= {pkt.slope[1], pkt.slope[0]};
      lane_sh_q[4] <= {sync_en_q, pkt.err_flag, pkt.overflow,
                       pkt.any_hit_flag, pkt.slope[2]};
    end else begin
      for (int l = 0; l < `LANES; l++) begin
        lane_sh_q[l] <= {lane_sh_q[l][6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hdr_q <= 1'b0;
    end else begin
      hdr_q <= tick_q;
    end
  end

  always_comb begin
    for (int l = 0; l < `LANES; l++) begin
      lanes[l] = lane_sh_q[l][7];
    end
  end

  assign trig_hdr_slot = hdr_q;
  assign status        = status_q;
  assign cmd           = cmd_q;
  assign tick40        = tick_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_trig_frame;
    frame_ok && !forbidden && shreg_q[`CMD_TRIG];
  endsequence

  sequence s_lost_frame;
    (state_q == LOCKED) && (bitcnt_q == 3'h7) && !frame_hit;
  endsequence

  a_trig_one_period: assert property (
    s_trig_frame |=> cmd_q.trig [*8])
    else $error("trigger not held for one period");

  a_srst_width: assert property (
    srst_start |=> cmd_q.soft_rst [*8] ##1 cmd_q.soft_rst [*4])
    else $error("soft reset not one and a half periods");

  a_forbidden_quiet: assert property (
    frame_ok && forbidden |=> !cmd_q.trig && !cmd_q.cal && !cmd_q.clr
                              && status_q.cmd_err)
    else $error("forbidden frame produced a command");

  a_sync_halt: assert property (
    s_lost_frame |=> !tick_q && status_q.sync_lost && !status_q.sync_ok)
    else $error("tick ran without sync pattern");

  a_tick_spacing: assert property (
    tick_q |=> !tick_q [*7])
    else $error("period ticks closer than eight bits");

  a_lane_sync_bit: assert property (
    tick_q |=> lanes[4] == $past(sync_en_q))
    else $error("sync bit missing from frame");

  a_overflow_flag: assert property (
    tick_q |-> gath.overflow == ($countones(match_q) > `MAX_SEG))
    else $error("overflow flag wrong for the segment count");

  a_sync_gap: assert property (
    srst_start |=> !sync_en_q [*8] ##1 !sync_en_q [*8])
    else $error("sync bit returned too early after soft reset");

  a_fifo_latency: assert property (
    pop |-> push ##1 (fifo_count == CW'(`LAT_FILL)))
    else $error("queue depth left the fixed latency");

  a_cmd_clears: assert property (
    $fell(cmd_q.trig) |-> $past(hold_q) == 4'h1)
    else $error("trigger ended off the period boundary");

endmodule

// ===== logic/stub_readout_params.svh
`ifndef STUB_READOUT_PARAMS_SVH
`define STUB_READOUT_PARAMS_SVH

// Correlation and segment sizes
`define CHANNELS       254
`define MAX_SEG        3
`define LANES          5
`define FRAME_BITS     8

// Timing: crossing period and serial bit clock
`define PERIOD_NS      25
`define BIT_CLK_MHZ    320
`define BITS_PER_PERIOD ((`PERIOD_NS * `BIT_CLK_MHZ) / 1000)
`define SOFT_RST_BITS  ((3 * `BITS_PER_PERIOD) / 2)

// Command frame layout
`define SYNC_PATTERN   3'h6
`define SYNC_MSB       7
`define SYNC_LSB       5
`define CMD_SOFT_RST   4
`define CMD_TRIG       3
`define CMD_CAL        2
`define CMD_CLR        1
`define CMD_MARK       0

// Slope table
`define TBL_REGS       15
`define TBL_PROG_CODES 5'h1e

// Readout path
`define FIFO_DEPTH     32
`define LAT_FILL       3
`define SYNC_GAP       2

`endif

// ===== logic/stub_readout_pkg.sv
package stub_readout_pkg;

  typedef logic [7:0] seg_addr_t;
  typedef logic [3:0] slope_t;
  typedef logic [4:0] bend_t;

  typedef struct packed {
    logic                any_hit_flag;
    logic                overflow;
    logic                err_flag;
    seg_addr_t [2:0]     addr;
    slope_t    [2:0]     slope;
  } seg_pkt_t;

  typedef struct packed {
    logic soft_rst;
    logic trig;
    logic cal;
    logic clr;
  } fcmd_t;

  typedef struct packed {
    logic sync_ok;
    logic sync_lost;
    logic cmd_err;
    logic buf_full;
    logic delay_err;
  } status_t;

  typedef enum logic {HUNT, LOCKED} lock_state_t;

endpackage

// ===== verif/backend_model.sv
`timescale 1ns/100ps

module backend_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Fast command stream
  output logic            fcmd_bit,
  output logic            last_bit,
  // Packet lanes
  input  wire logic [4:0] lanes,
  input  wire logic       trig_hdr_slot,
  output logic [4:0][7:0] rx_word,
  output int              rx_count
);
  logic [7:0]      q[$];
  logic [7:0]      cur;
  logic [4:0][7:0] acc;
  int              bit_idx;
  int              rx_idx;

  task automatic push(input logic [7:0] f);
    q.push_back(f);
  endtask

  // Idle frames keep the device's period tick alive between commands
  always @(negedge clk_sys) begin
    if (rst) begin
      bit_idx  <= 0;
      fcmd_bit <= 1'b0;
      last_bit <= 1'b0;
    end else begin
      if (bit_idx == 0) begin
        if (q.size() != 0) cur = q.pop_front();
        else cur = 8'hc1;
      end
      fcmd_bit <= cur[7 - bit_idx];
      last_bit <= (bit_idx == 7);
      bit_idx  <= (bit_idx + 1) % 8;
    end
  end

  // Frame capture restarts on every header slot, MSB first per lane
  always @(negedge clk_sys) begin
    if (rst) begin
      rx_idx = 8;
      rx_count <= 0;
    end else begin
      if (trig_hdr_slot) rx_idx = 0;
      if (rx_idx < 8) begin
        for (int l = 0; l < 5; l++) acc[l][7 - rx_idx] = lanes[l];
        rx_idx = rx_idx + 1;
        if (rx_idx == 8) begin
          rx_word  <= acc;
          rx_count <= rx_count + 1;
        end
      end
    end
  end
endmodule

// ===== verif/stub_readout_test.sv
`timescale 1ns/100ps
`define CHECK(what, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("unexpected %s: expected %h seen %h", what, exp, got); \
    end \
  end

module stub_readout_test;
  import stub_readout_pkg::*;

  logic            clk_sys = 1'b0;
  logic            rst = 1'b1;
  logic            fcmd_bit;
  logic [253:0]    match_bits = '0;
  bend_t [253:0]   bend_codes = '0;
  logic [253:0]    hit_bits = '0;
  logic            buf_full_in = 1'b0;
  logic            delay_err_in = 1'b0;
  logic            tbl_wr_en = 1'b0;
  logic [3:0]      tbl_idx = 4'h0;
  logic [7:0]      tbl_wr_data = 8'h00;
  logic [7:0]      tbl_rd_data;
  status_t         status;
  fcmd_t           cmd;
  logic            tick40;
  logic [4:0]      lanes;
  logic            trig_hdr_slot;
  logic [4:0][7:0] rx_word;
  int              rx_count;
  int              bad_count = 0;
  int              check_count = 0;
  int              n0;
  logic [7:0]      frm [9] = '{8'hc9, 8'hc5, 8'hc3, 8'hcb, 8'hc7,
                               8'hcd, 8'hcf, 8'hd9, 8'hd5};
  logic [3:0]      exp_cmd [9] = '{4'h4, 4'h2, 4'h1, 4'h5, 4'h3,
                                   4'h0, 4'h0, 4'h0, 4'h0};

  always #12.5 clk_sys = ~clk_sys;

  stub_readout #(.CHANNELS(254), .DEPTH(32)) DUT (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .fcmd_bit      (fcmd_bit),
    .match_bits    (match_bits),
    .bend_codes    (bend_codes),
    .hit_bits      (hit_bits),
    .buf_full_in   (buf_full_in),
    .delay_err_in  (delay_err_in),
    .tbl_wr_en     (tbl_wr_en),
    .tbl_idx       (tbl_idx),
    .tbl_wr_data   (tbl_wr_data),
    .tbl_rd_data   (tbl_rd_data),
    .status        (status),
    .cmd           (cmd),
    .tick40        (tick40),
    .lanes         (lanes),
    .trig_hdr_slot (trig_hdr_slot)
  );

  backend_model far_end (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .fcmd_bit      (fcmd_bit),
    .last_bit      (),
    .lanes         (lanes),
    .trig_hdr_slot (trig_hdr_slot),
    .rx_word       (rx_word),
    .rx_count      (rx_count)
  );

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic tbl_read(input logic [3:0] idx, input logic [7:0] exp);
    @(negedge clk_sys);
    tbl_idx = idx;
    @(negedge clk_sys);
    `CHECK("slope table", exp, tbl_rd_data)
  endtask

  // Frame goes out whole; the tick and the command follow its last bit
  task automatic send_cmd(input logic [7:0] f, input logic tk,
                          input fcmd_t exp, input int stand);
    int n;
    n = 0;
    far_end.push(f);
    @(posedge clk_sys);
    while (far_end.q.size() != 0 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    while (far_end.last_bit !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (2) @(negedge clk_sys);
    `CHECK("tick40", tk, tick40)
    for (int i = 0; i < stand; i++) begin
      `CHECK("cmd", exp, cmd)
      @(negedge clk_sys);
    end
    `CHECK("cmd after", fcmd_t'(4'h0), cmd)
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    wrap_up();
  end

  initial begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    `CHECK("status", status_t'(5'h00), status)
    tbl_read(4'h0, 8'h00);
    tbl_read(4'h8, 8'h88);
    tbl_read(4'he, 8'hee);
    tbl_read(4'hf, 8'h00);
    for (int i = 0; i < 9; i++) begin
      send_cmd(frm[i], 1'b1, fcmd_t'(exp_cmd[i]), 8);
    end
    `CHECK("cmd error", 1'b1, status.cmd_err)
    send_cmd(8'h00, 1'b0, fcmd_t'(4'h0), 1);
    repeat (2) @(negedge clk_sys);
    `CHECK("sync lost", 1'b1, status.sync_lost)
    `CHECK("sync ok", 1'b0, status.sync_ok)
    send_cmd(8'hc9, 1'b1, fcmd_t'(4'h4), 8);
    `CHECK("sync ok", 1'b1, status.sync_ok)
    send_cmd(8'hd1, 1'b1, fcmd_t'(4'h8), 12);
    `CHECK("sync lost", 1'b0, status.sync_lost)
    `CHECK("cmd error", 1'b0, status.cmd_err)
    // Refill the readout queue after the flush before sending data
    repeat (96) @(negedge clk_sys);
    @(negedge clk_sys);
    tbl_idx     = 4'h3;
    tbl_wr_data = 8'h53;
    tbl_wr_en   = 1'b1;
    @(negedge clk_sys);
    tbl_wr_en = 1'b0;
    tbl_read(4'h3, 8'h53);
    // Four segments with the third-lowest carrying code 10000 from its default entry
    n0 = 0;
    while (tick40 !== 1'b1 && n0 < 20) begin
      @(negedge clk_sys);
      n0++;
    end
    n0 = rx_count;
    match_bits[30] = 1'b1;
    match_bits[20] = 1'b1;
    match_bits[9]  = 1'b1;
    match_bits[5]  = 1'b1;
    bend_codes[5]  = 5'h1a;
    bend_codes[9]  = 5'h07;
    bend_codes[20] = 5'h10;
    hit_bits[100]  = 1'b1;
    buf_full_in    = 1'b1;
    repeat (8) @(negedge clk_sys);
    match_bits  = '0;
    hit_bits    = '0;
    buf_full_in = 1'b0;
    while (rx_count < n0 + 5) @(negedge clk_sys);
    `CHECK("early lane", 8'h00, rx_word[0])
    `CHECK("sync slot", 1'b1, rx_word[4][7])
    while (rx_count < n0 + 6) @(negedge clk_sys);
    `CHECK("addr 1", 8'h05, rx_word[0])
    `CHECK("addr 2", 8'h09, rx_word[1])
    `CHECK("addr 3", 8'h14, rx_word[2])
    `CHECK("slopes", 8'h5d, rx_word[3])
    `CHECK("flags", 8'hf8, rx_word[4])
    `CHECK("buf full", 1'b1, status.buf_full)
    `CHECK("delay err", 1'b0, status.delay_err)
    wrap_up();
  end
endmodule
